// File: core/bpsc_pin_strap.sv
// strap latching, host port selection and shared pin steering
`timescale 1ns/1ps
`default_nettype none
module bpsc_pin_strap (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic infrared_strap_n,
  input wire logic half_duplex_strap_n,
  input wire logic i2cSpiSel,
  input wire logic addr_sel0_or_chip_sel_n,
  input wire logic addr_sel1_or_serial_in,
  input wire logic serialClk,
  input wire logic spiOutData,
  input wire logic spiOutActive,
  output logic spiOut,
  output logic spiOutEn,
  output logic spiClkEdge,
  input wire logic irqActive,
  output logic irqOut,
  output logic irqOutEn,
  input wire logic uartTxData,
  input wire logic irTxData,
  output logic txPin,
  input wire logic rxPin,
  output logic rxData,
  input wire logic autoRtsLevel,
  input wire logic autoRtsEnable,
  input wire logic gpoRts,
  input wire logic txDirection,
  output logic request_to_send_a_n,
  input wire logic clear_to_send_a_n,
  input wire logic autoCtsEnable,
  output logic txAllowed,
  output logic ctsGpi,
  input wire logic [7:0] pin_function_control_reg,
  input wire logic [7:0] pin_direction_reg,
  input wire logic [7:0] gpioOutValue,
  input wire logic [7:0] modemOutValue,
  input wire logic [7:0] modemOutDrive,
  input wire logic [7:0] sharedPinIn,
  output logic [7:0] sharedPinOut,
  output logic [7:0] sharedPinOutEn,
  output logic [7:0] gpioInValue,
  output logic [7:0] modemInValue,
  output bpsc_pkg::bpsc_strap_s strapOut,
  output bpsc_pkg::bpsc_host_s hostOut
);
  import bpsc_pkg::*;

  // two-flop synchronisers for every pin input
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] syncA_reg, syncA_next, syncB_reg, syncB_next;
  logic [NSYNC-1:0] rawIn;
  assign rawIn = {i2cSpiSel, sharedPinIn, clear_to_send_a_n, rxPin,
                  serialClk, addr_sel1_or_serial_in,
                  addr_sel0_or_chip_sel_n, half_duplex_strap_n,
                  infrared_strap_n};
  always_comb begin
    syncA_next = rawIn;
    syncB_next = syncA_reg;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_reg <= '1;
      syncB_reg <= '1;
    end else begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
    end
  end
  logic selS, irS, hdS, a0S, a1S, sclS, rxS, ctsS;
  logic [7:0] shS;
  assign {selS, shS, ctsS, rxS, sclS, a1S, a0S, hdS, irS} = syncB_reg;

  // strap sampler: sample once after release, then hold
  bpsc_state_e state_reg, state_next;
  logic [1:0] strap_reg, strap_next;
  always_comb begin
    state_next = state_reg;
    strap_next = strap_reg;
    case (state_reg)
      ST_SAMPLE: state_next = ST_FILL;
      // synchroniser still shows its reset ones until here
      ST_FILL: state_next = ST_SETTLE;
      ST_SETTLE: begin
        strap_next[STRAP_IR_BIT] = irS;
        strap_next[STRAP_HD_BIT] = hdS;
        state_next = ST_HELD;
      end
      ST_HELD: state_next = ST_HELD;
      default: state_next = ST_SAMPLE;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_SAMPLE;
      strap_reg <= STRAP_RESET;
    end else begin
      state_reg <= state_next;
      strap_reg <= strap_next;
    end
  end
  logic irMode, hdMode, strapsReady;
  assign irMode = ~strap_reg[STRAP_IR_BIT];
  assign hdMode = ~strap_reg[STRAP_HD_BIT];
  assign strapsReady = (state_reg == ST_HELD);

  // registered pin outputs
  logic txPin_next, rts_next, spiOut_next, spiOutEn_next;
  logic [7:0] shOut_next, shEn_next;
  logic sclPrev_reg;
  always_comb begin
    // transmit idles until straps are held
    if (!strapsReady)
      txPin_next = 1'b1;
    else if (irMode)
      txPin_next = irTxData;
    else
      txPin_next = uartTxData;
    if (hdMode)
      rts_next = ~txDirection;
    else if (autoRtsEnable)
      rts_next = autoRtsLevel;
    else
      rts_next = gpoRts;
    spiOutEn_next = ~selS & ~a0S & spiOutActive;
    spiOut_next = spiOutEn_next & spiOutData;
    for (int i = 0; i < NUM_SHARED; i++) begin
      shEn_next[i] = pin_function_control_reg[i] ? modemOutDrive[i]
                                                 : pin_direction_reg[i];
      shOut_next[i] = pin_function_control_reg[i] ? modemOutValue[i]
                                                  : gpioOutValue[i];
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txPin <= 1'b1;
      request_to_send_a_n <= 1'b1;
      spiOut <= 1'b0;
      spiOutEn <= 1'b0;
      sharedPinOut <= 8'h00;
      sharedPinOutEn <= 8'h00;
      sclPrev_reg <= 1'b1;
    end else begin
      txPin <= txPin_next;
      request_to_send_a_n <= rts_next;
      spiOut <= spiOut_next;
      spiOutEn <= spiOutEn_next;
      sharedPinOut <= shOut_next;
      sharedPinOutEn <= shEn_next;
      sclPrev_reg <= sclS;
    end
  end

  // relied on: active edge is rising for SPI mode 0
  assign spiClkEdge = ~selS & sclS & ~sclPrev_reg;
  // open drain: drive low only while active
  assign irqOut = 1'b0;
  assign irqOutEn = irqActive;
  assign rxData = strapsReady ? rxS : ~irMode;
  assign txAllowed = ~autoCtsEnable | ~ctsS;
  assign ctsGpi = ctsS;
  assign gpioInValue = shS & ~pin_function_control_reg;
  assign modemInValue = shS & pin_function_control_reg;
  assign strapOut = '{infraredMode: irMode, halfDuplexMode: hdMode};
  assign hostOut = '{spiMode: ~selS,
                     i2cAddr: selS ? {a1S, a0S} : 2'h0,
                     spiSelected: ~selS & ~a0S,
                     spiDataIn: ~selS & a1S};

  a_strap_held: assert property (
    @(posedge mclk) disable iff (!rst_n)
    strapsReady |=> $stable(strap_reg))
    else $error("strap changed after latch");
  a_tx_idle: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !strapsReady |=> txPin)
    else $error("tx not idle before straps held");
  a_rx_ignore: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !strapsReady |-> rxData)
    else $error("rx not ignored before straps held");
  a_hd_rts: assert property (
    @(posedge mclk) disable iff (!rst_n)
    hdMode |=> request_to_send_a_n == ~$past(txDirection))
    else $error("rts not direction control");
  a_rts_flow: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !hdMode && autoRtsEnable |=>
      request_to_send_a_n == $past(autoRtsLevel))
    else $error("rts not flow control");
  a_ir_tx: assert property (
    @(posedge mclk) disable iff (!rst_n)
    strapsReady && irMode |=> txPin == $past(irTxData))
    else $error("ir tx not routed");
  a_spi_hiz: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (selS || a0S) |=> !spiOutEn)
    else $error("spi out driven while idle");
  a_irq_od: assert property (
    @(posedge mclk) disable iff (!rst_n)
    irqOutEn == irqActive && !irqOut)
    else $error("irq not open drain");
  a_port_sel: assert property (
    @(posedge mclk) disable iff (!rst_n)
    strapsReady |-> hostOut.spiMode == !$past(i2cSpiSel, 2))
    else $error("port select wrong");
  a_i2c_addr: assert property (
    @(posedge mclk) disable iff (!rst_n)
    strapsReady && selS |-> hostOut.i2cAddr ==
      {$past(addr_sel1_or_serial_in, 2), $past(addr_sel0_or_chip_sel_n, 2)})
    else $error("i2c address wrong");
  a_spi_cs: assert property (
    @(posedge mclk) disable iff (!rst_n)
    strapsReady |-> hostOut.spiSelected ==
      (!$past(i2cSpiSel, 2) && !$past(addr_sel0_or_chip_sel_n, 2)))
    else $error("chip select wrong");
  a_spi_din: assert property (
    @(posedge mclk) disable iff (!rst_n)
    strapsReady |-> hostOut.spiDataIn ==
      (!$past(i2cSpiSel, 2) && $past(addr_sel1_or_serial_in, 2)))
    else $error("spi data in wrong");
  a_cts_gate: assert property (
    @(posedge mclk) disable iff (!rst_n)
    strapsReady && autoCtsEnable && $past(clear_to_send_a_n, 2) |->
      !txAllowed)
    else $error("cts gate wrong");
  a_shared_dir: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !pin_function_control_reg[0] |=>
      sharedPinOutEn[0] == $past(pin_direction_reg[0]))
    else $error("gpio direction wrong");
  c_ir_mode: cover property (@(posedge mclk) strapsReady && irMode);
  c_hd_mode: cover property (@(posedge mclk) strapsReady && hdMode);
  c_spi_sel: cover property (@(posedge mclk) hostOut.spiSelected);
  c_spi_edge: cover property (@(posedge mclk) spiClkEdge);
  c_strap_latch: cover property (@(posedge mclk) $rose(strapsReady));
endmodule
`default_nettype wire

// File: include/bpsc_pkg.sv
// package for the pin strap and pin steering block
package bpsc_pkg;
  localparam int RESET_MIN_NS = 40;
  localparam int CLK_PERIOD_NS = 100;
  // at least one cycle, rounded up
  localparam int RESET_MIN_CYC =
      (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_SHARED = 8;
  localparam logic [7:0] PIN_FUNC_RESET = 8'h00;
  localparam logic [7:0] PIN_DIR_RESET = 8'h00;
  localparam logic [1:0] STRAP_RESET = 2'h3;
  localparam int STRAP_IR_BIT = 0;
  localparam int STRAP_HD_BIT = 1;
  typedef enum logic [1:0] {ST_SAMPLE, ST_FILL, ST_SETTLE,
                            ST_HELD} bpsc_state_e;
  typedef struct packed {
    logic infraredMode;
    logic halfDuplexMode;
  } bpsc_strap_s;
  typedef struct packed {
    logic spiMode;
    logic [1:0] i2cAddr;
    logic spiSelected;
    logic spiDataIn;
  } bpsc_host_s;
endpackage

// File: verification/bpsc_host_model.sv
// host side model: serial clock, chip select and data
`timescale 1ns/1ps
`default_nettype none
module bpsc_host_model (
  input wire logic i2cMode,
  input wire logic frame,
  input wire logic [7:0] txByte,
  output logic sclk,
  output logic csN,
  output logic sdi
);
  // clock parks at the port's idle level outside frames
  initial begin
    csN = 1'b1;
    sdi = 1'b0;
    sclk = i2cMode;
    forever begin
      @(posedge frame or i2cMode);
      if (frame) begin
        csN = 1'b0;
        for (int i = 7; i >= 0; i--) begin
          sdi = txByte[i];
          #400 sclk = ~i2cMode;
          #400 sclk = i2cMode;
        end
        csN = 1'b1;
        // released line: never the last value
        sdi = ~sdi;
      end else begin
        sclk = i2cMode;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// bench for the pin strap block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bpsc_pkg::*;
  logic mclk = 0, rst_n = 0, irN = 1, hdN = 1, sel = 1, rxPin = 1;
  logic spiAct = 0, irq = 0, uTx = 1, irTx = 0, frame = 0;
  logic rtsLvl = 0, rtsEn = 0, gpo = 0, txDir = 0, ctsN = 1, ctsEn = 0;
  logic [7:0] func = '0, dir = '0, gOut = '0, mOut = '0, mDrv = '0;
  logic [7:0] rxByte = '0;
  logic [9:0] rows [4] = '{10'h17a, 10'h18d, 10'h077, 10'h281};
  logic sclk, csN, sdi, spiOut, spiOutEn, spiClkEdge, irqOut, irqOutEn;
  logic txPin, rxData, rtsN, txAllowed, ctsGpi;
  logic [7:0] pinOut, pinOutEn, gIn, mIn;
  bpsc_strap_s strap;
  bpsc_host_s host;
  int n_fail = 0, checks = 0, nEdge = 0;
  always #50 mclk = ~mclk;
  bpsc_host_model i_bpsc_host_model (.i2cMode(sel), .frame(frame),
    .txByte(8'ha5), .sclk(sclk), .csN(csN), .sdi(sdi));
  bpsc_pin_strap i_bpsc_pin_strap (.mclk(mclk), .rst_n(rst_n),
    .infrared_strap_n(irN), .half_duplex_strap_n(hdN), .i2cSpiSel(sel),
    .addr_sel0_or_chip_sel_n(csN), .addr_sel1_or_serial_in(sdi),
    .serialClk(sclk), .spiOutData(1'b1), .spiOutActive(spiAct),
    .spiOut(spiOut), .spiOutEn(spiOutEn), .spiClkEdge(spiClkEdge),
    .irqActive(irq), .irqOut(irqOut), .irqOutEn(irqOutEn),
    .uartTxData(uTx), .irTxData(irTx), .txPin(txPin), .rxPin(rxPin),
    .rxData(rxData), .autoRtsLevel(rtsLvl), .autoRtsEnable(rtsEn),
    .gpoRts(gpo), .txDirection(txDir), .request_to_send_a_n(rtsN),
    .clear_to_send_a_n(ctsN), .autoCtsEnable(ctsEn),
    .txAllowed(txAllowed), .ctsGpi(ctsGpi),
    .pin_function_control_reg(func), .pin_direction_reg(dir),
    .gpioOutValue(gOut), .modemOutValue(mOut), .modemOutDrive(mDrv),
    .sharedPinIn(8'hc3), .sharedPinOut(pinOut),
    .sharedPinOutEn(pinOutEn), .gpioInValue(gIn), .modemInValue(mIn),
    .strapOut(strap), .hostOut(host));
  // gather bits shifted in by the host
  always @(negedge mclk) if (spiClkEdge === 1'b1) begin
    rxByte <= {rxByte[6:0], host.spiDataIn};
    nEdge <= nEdge + 1;
  end
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic waitc(int n);
    repeat (n) @(negedge mclk);
  endtask
  initial begin
    #300000;
    n_fail++;
    finish_test;
  end
  initial begin
    waitc(4);
    chk("txIdle", txPin, 1);
    chk("pinEnRst", pinOutEn, 0);
    rst_n = 1;
    waitc(4);
    chk("strapOff", strap, 0);
    uTx = 0;
    waitc(2);
    chk("uartTx", txPin, 0);
    foreach (rows[r]) begin
      {txDir, rtsEn, rtsLvl, gpo, irq, ctsN, ctsEn} = rows[r][9:3];
      waitc(4);
      chk("rts", rtsN, rows[r][2]);
      chk("irqEn", irqOutEn, rows[r][1]);
      chk("irqLow", irqOut, 0);
      chk("txOk", txAllowed, rows[r][0]);
      chk("ctsIn", ctsGpi, ctsN);
    end
    $display("rows done");
    {func, dir, gOut, mOut, mDrv} = {8'hf0, 8'h0c, 8'haa, 8'h55, 8'h30};
    waitc(4);
    chk("pinEn", pinOutEn, 8'h3c);
    chk("pinOut", pinOut, 8'h5a);
    chk("gpioIn", gIn & 8'h0f, 8'h03);
    chk("modemIn", mIn & 8'hf0, 8'hc0);
    chk("addr", host.i2cAddr, 2'h1);
    chk("i2c", host.spiMode, 0);
    $display("shared pins done");
    sel = 0;
    spiAct = 1;
    waitc(4);
    frame = 1;
    waitc(10);
    chk("spiSel", host.spiSelected, 1);
    chk("spiEn", spiOutEn, 1);
    chk("spiOut", spiOut, 1);
    waitc(70);
    frame = 0;
    waitc(4);
    chk("spiByte", rxByte, 8'ha5);
    chk("edges", 8'(nEdge), 8);
    chk("spiOff", spiOutEn, 0);
    chk("spiOutLow", spiOut, 0);
    chk("spiMode", host.spiMode, 1);
    $display("spi frame done");
    {irN, hdN, txDir, uTx, irTx, rxPin} = 6'h0a;
    rst_n = 0;
    waitc(1);
    chk("rtsRst", rtsN, 1);
    chk("txRst", txPin, 1);
    chk("rxIgn", rxData, 1);
    rst_n = 1;
    waitc(4);
    chk("strapOn", strap, 2'h3);
    chk("hdRts", rtsN, 0);
    chk("irTx", txPin, 1);
    {irN, hdN, txDir, rxPin} = 4'hc;
    waitc(4);
    chk("strapHeld", strap, 2'h3);
    chk("hdRts2", rtsN, 1);
    chk("irRx", rxData, 0);
    $display("strap reset done");
    finish_test;
  end
endmodule
`default_nettype wire
